// file: pdmc_pkg.sv
package pdmc_pkg;

    localparam logic [1:0] ADDR_MODE_CLK = 2'h0;
    localparam logic [1:0] ADDR_STANDBY  = 2'h1;
    localparam logic [1:0] ADDR_STATUS   = 2'h2;

    localparam int SLP_SEL_BIT = 7;
    localparam int LOW_SPD_BIT = 6;
    localparam int DIR_XFR_BIT = 5;
    localparam int MA_MSB      = 4;
    localparam int MA_LSB      = 2;
    localparam int SA_MSB      = 1;
    localparam int SA_LSB      = 0;
    localparam int RSVD_BIT    = 7;
    localparam int WDOG_BIT    = 3;

    localparam logic [7:0] MODE_CLK_RST  = 8'h00;
    localparam logic [7:0] STANDBY_RST   = 8'h00;
    localparam logic [7:0] STANDBY_WMASK = 8'h7f;
    localparam logic [2:0] ACT_OSC_CODE  = 3'h0;
    localparam logic [1:0] SUB_SA_DIV4   = 2'h1;
    localparam logic [1:0] SHIFT_DIV2    = 2'h1;
    localparam logic [1:0] SHIFT_DIV4    = 2'h2;
    localparam logic [1:0] SHIFT_DIV8    = 2'h3;

    typedef enum logic [2:0] {
        MODE_ACTIVE    = 3'b000,
        MODE_SLEEP     = 3'b001,
        MODE_SUBSLEEP  = 3'b010,
        MODE_STANDBY   = 3'b011,
        MODE_SUBACTIVE = 3'b100
    } pdmc_mode_e;

    // sleep is honoured only from a running mode and never for the undefined
    // sleep-select plus low-speed combination without direct transfer or standby select
    function automatic logic pdmc_sleep_ok(input logic [7:0] cfg, input logic stbySel,
                                           input pdmc_mode_e cur);
        logic running;
        running = (cur == MODE_ACTIVE) || (cur == MODE_SUBACTIVE);
        return running && (cfg[DIR_XFR_BIT] || stbySel
                           || !(cfg[SLP_SEL_BIT] && cfg[LOW_SPD_BIT]));
    endfunction

    function automatic pdmc_mode_e pdmc_sleep_target(input logic [7:0] cfg,
                                                     input logic stbySel);
        pdmc_mode_e t;
        if (cfg[DIR_XFR_BIT])
            t = cfg[LOW_SPD_BIT] ? MODE_SUBACTIVE : MODE_ACTIVE;
        else if (stbySel)
            t = MODE_STANDBY;
        else
            t = cfg[SLP_SEL_BIT] ? MODE_SUBSLEEP : MODE_SLEEP;
        return t;
    endfunction

    function automatic pdmc_mode_e pdmc_wake_target(input logic [7:0] cfg, input pdmc_mode_e cur);
        return (cur != MODE_STANDBY && cfg[LOW_SPD_BIT]) ? MODE_SUBACTIVE : MODE_ACTIVE;
    endfunction

    function automatic logic [2:0] pdmc_active_code(input logic [2:0] ma);
        return ma[2] ? ma : ACT_OSC_CODE;
    endfunction

    function automatic logic [1:0] pdmc_sub_shift(input logic [1:0] sa);
        logic [1:0] s;
        if (sa[1])
            s = SHIFT_DIV2;
        else if (sa == SUB_SA_DIV4)
            s = SHIFT_DIV4;
        else
            s = SHIFT_DIV8;
        return s;
    endfunction

endpackage

// file: pdmc_ctl_if.sv
interface pdmc_ctl_if;
    logic [7:0] modeClkReg;
    logic [7:0] standbyReg;

    modport owner (output modeClkReg, output standbyReg);
    modport user  (input modeClkReg, input standbyReg);
endinterface

// file: pdmc_regs.sv
module pdmc_regs
    import pdmc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       wrModeClk,
    input  wire logic       wrStandby,
    input  wire logic [7:0] wrData,
    pdmc_ctl_if.owner       ctl
);
    logic [7:0] modeClk_r;
    logic [7:0] standby_r;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            modeClk_r <= MODE_CLK_RST;
            standby_r <= STANDBY_RST;
        end
        else
        begin
            if (wrModeClk)
                modeClk_r <= wrData;
            if (wrStandby)
                standby_r <= wrData & STANDBY_WMASK;
        end
    end

    assign ctl.modeClkReg = modeClk_r;
    assign ctl.standbyReg = standby_r;
endmodule

// file: pdmc_mode_fsm.sv
module pdmc_mode_fsm
    import pdmc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       standbySelect,
    input  wire logic       sleepExec,
    input  wire logic       wakeIrq,
    pdmc_ctl_if.user        ctl,
    output pdmc_mode_e      mode_r,
    output logic [2:0]      activeCode_r,
    output logic [1:0]      subShift_r
);
    pdmc_mode_e mode_nxt;
    wire        halted;
    wire        sleepTaken;

    assign halted     = (mode_r == MODE_SLEEP) || (mode_r == MODE_SUBSLEEP)
                      || (mode_r == MODE_STANDBY);
    assign sleepTaken = sleepExec && pdmc_sleep_ok(ctl.modeClkReg, standbySelect, mode_r);

    always_comb
    begin
        mode_nxt = mode_r;
        case (mode_r)
            MODE_ACTIVE, MODE_SUBACTIVE:
                if (sleepTaken)
                    mode_nxt = pdmc_sleep_target(ctl.modeClkReg, standbySelect);
            default:
                if (halted && wakeIrq)
                    mode_nxt = pdmc_wake_target(ctl.modeClkReg, mode_r);
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_r       <= MODE_ACTIVE;
            activeCode_r <= ACT_OSC_CODE;
            subShift_r   <= SHIFT_DIV8;
        end
        else
        begin
            mode_r <= mode_nxt;
            if (sleepTaken)
            begin
                activeCode_r <= pdmc_active_code(ctl.modeClkReg[MA_MSB:MA_LSB]);
                subShift_r   <= pdmc_sub_shift(ctl.modeClkReg[SA_MSB:SA_LSB]);
            end
        end
    end
endmodule

// file: pdmc_top.sv
module pdmc_top
    import pdmc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic [1:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    output logic [7:0]      regRdData,
    input  wire logic       standbySelect,
    input  wire logic       wdtClkIsOsc,
    input  wire logic       sleepExec,
    input  wire logic       wakeIrq,
    output pdmc_mode_e      modeState,
    output logic            cpuHalted,
    output logic [2:0]      activeClkCode,
    output logic [1:0]      subClkShift,
    output logic            twowireStandby,
    output logic            serialStandby,
    output logic            converterStandby,
    output logic            watchdogStandby,
    output logic            thirdTimerStandby,
    output logic            secondTimerStandby,
    output logic            firstTimerStandby
);
    pdmc_ctl_if ctl ();

    logic [7:0] rdData_r;
    logic       halted_r;
    logic [6:0] standbyOut_r;
    logic [6:0] standbyOut_nxt;

    wire        selModeClk;
    wire        selStandby;
    wire        selStatus;
    wire        wrModeClk;
    wire        wrStandby;
    wire [7:0]  statusWord;
    wire [7:0]  rdMux;
    wire        sleepTaken;
    wire        haltNxt;
    pdmc_mode_e sleepTarget;
    pdmc_mode_e wakeTarget;

    // address decode
    assign selModeClk = (regAddr == ADDR_MODE_CLK);
    assign selStandby = (regAddr == ADDR_STANDBY);
    assign selStatus  = (regAddr == ADDR_STATUS);
    assign wrModeClk  = regWrEn && selModeClk;
    assign wrStandby  = regWrEn && selStandby;

    pdmc_regs u_regs (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .wrModeClk (wrModeClk),
        .wrStandby (wrStandby),
        .wrData    (regWrData),
        .ctl       (ctl.owner)
    );

    pdmc_mode_fsm u_fsm (
        .sys_clk       (sys_clk),
        .arst_n        (arst_n),
        .standbySelect (standbySelect),
        .sleepExec     (sleepExec),
        .wakeIrq       (wakeIrq),
        .ctl           (ctl.user),
        .mode_r        (modeState),
        .activeCode_r  (activeClkCode),
        .subShift_r    (subClkShift)
    );

    // status shows applied clocks and current mode, read only
    assign statusWord = {subClkShift, activeClkCode, modeState};

    assign rdMux = selModeClk ? ctl.modeClkReg
                 : selStandby ? (ctl.standbyReg & STANDBY_WMASK)
                 : selStatus  ? statusWord
                 : 8'h00;

    assign sleepTaken  = sleepExec && pdmc_sleep_ok(ctl.modeClkReg, standbySelect, modeState);
    assign sleepTarget = pdmc_sleep_target(ctl.modeClkReg, standbySelect);
    assign wakeTarget  = pdmc_wake_target(ctl.modeClkReg, modeState);

    // halt flag follows the mode the fsm enters this edge
    assign haltNxt = sleepTaken ? (sleepTarget != MODE_ACTIVE && sleepTarget != MODE_SUBACTIVE)
                   : (wakeIrq ? 1'b0 : cpuHalted);

    assign standbyOut_nxt[6:4] = ctl.standbyReg[6:4];
    assign standbyOut_nxt[2:0] = ctl.standbyReg[2:0];
    assign standbyOut_nxt[WDOG_BIT] = ctl.standbyReg[WDOG_BIT] && !wdtClkIsOsc;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdData_r     <= 8'h00;
            halted_r     <= 1'b0;
            standbyOut_r <= 7'h00;
        end
        else
        begin
            rdData_r     <= regRdEn ? rdMux : 8'h00;
            halted_r     <= haltNxt;
            standbyOut_r <= standbyOut_nxt;
        end
    end

    assign regRdData          = rdData_r;
    assign cpuHalted          = halted_r;
    assign twowireStandby     = standbyOut_r[6];
    assign serialStandby      = standbyOut_r[5];
    assign converterStandby   = standbyOut_r[4];
    assign watchdogStandby    = standbyOut_r[3];
    assign thirdTimerStandby  = standbyOut_r[2];
    assign secondTimerStandby = standbyOut_r[1];
    assign firstTimerStandby  = standbyOut_r[0];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    property p_sleep_mode;
        sleepTaken |=> (modeState == $past(sleepTarget));
    endproperty
    a_sleep_mode: assert property (p_sleep_mode)
        else $error("mode after sleep does not match config");

    property p_active_osc;
        (sleepTaken && !ctl.modeClkReg[MA_MSB]) |=> (activeClkCode == ACT_OSC_CODE);
    endproperty
    a_active_osc: assert property (p_active_osc)
        else $error("active clock not undivided with top bit clear");

    property p_active_div;
        (sleepTaken && ctl.modeClkReg[MA_MSB])
            |=> (activeClkCode == $past(ctl.modeClkReg[MA_MSB:MA_LSB]));
    endproperty
    a_active_div: assert property (p_active_div)
        else $error("active clock code not applied");

    property p_clock_hold;
        !sleepTaken |=> ($stable(activeClkCode) && $stable(subClkShift));
    endproperty
    a_clock_hold: assert property (p_clock_hold)
        else $error("clock changed without sleep");

    property p_write_no_clock;
        (wrModeClk && !sleepExec) ##1 !sleepExec |=> $stable(activeClkCode);
    endproperty
    a_write_no_clock: assert property (p_write_no_clock)
        else $error("clock field write took effect at once");

    property p_sub_div4;
        (sleepTaken && ctl.modeClkReg[SA_MSB:SA_LSB] == SUB_SA_DIV4)
            |=> (subClkShift == SHIFT_DIV4);
    endproperty
    a_sub_div4: assert property (p_sub_div4)
        else $error("sub clock code 01 not divide by four");

    property p_twowire;
        wrStandby ##1 !wrStandby |=> (twowireStandby == $past(regWrData[6], 2));
    endproperty
    a_twowire: assert property (p_twowire)
        else $error("two-wire standby output wrong");

    property p_serial;
        wrStandby ##1 !wrStandby |=> (serialStandby == $past(regWrData[5], 2));
    endproperty
    a_serial: assert property (p_serial)
        else $error("serial standby output wrong");

    property p_converter;
        wrStandby ##1 !wrStandby |=> (converterStandby == $past(regWrData[4], 2));
    endproperty
    a_converter: assert property (p_converter)
        else $error("converter standby output wrong");

    property p_wdog_sys;
        (ctl.standbyReg[WDOG_BIT] && !wdtClkIsOsc) |=> watchdogStandby;
    endproperty
    a_wdog_sys: assert property (p_wdog_sys)
        else $error("watchdog not in standby");

    property p_wdog_osc;
        wdtClkIsOsc |=> !watchdogStandby;
    endproperty
    a_wdog_osc: assert property (p_wdog_osc)
        else $error("oscillator watchdog was stopped");

    property p_timer_w;
        wrStandby ##1 !wrStandby |=> (thirdTimerStandby == $past(regWrData[2], 2));
    endproperty
    a_timer_w: assert property (p_timer_w)
        else $error("third timer standby output wrong");

    property p_timer_v;
        wrStandby ##1 !wrStandby |=> (secondTimerStandby == $past(regWrData[1], 2));
    endproperty
    a_timer_v: assert property (p_timer_v)
        else $error("second timer standby output wrong");

    property p_timer_a;
        wrStandby ##1 !wrStandby |=> (firstTimerStandby == $past(regWrData[0], 2));
    endproperty
    a_timer_a: assert property (p_timer_a)
        else $error("first timer standby output wrong");

    property p_rsvd_read;
        (regRdEn && selStandby) |=> (regRdData[RSVD_BIT] == 1'b0);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved standby bit read as one");

    property p_direct;
        (sleepTaken && ctl.modeClkReg[DIR_XFR_BIT])
            |=> (modeState == MODE_ACTIVE || modeState == MODE_SUBACTIVE) && !cpuHalted;
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct transfer halted the cpu");

    property p_standby_entry;
        (sleepTaken && !ctl.modeClkReg[DIR_XFR_BIT] && standbySelect)
            |=> (modeState == MODE_STANDBY) && cpuHalted;
    endproperty
    a_standby_entry: assert property (p_standby_entry)
        else $error("standby not entered");

    property p_wake;
        (cpuHalted && wakeIrq) |=> (modeState == $past(wakeTarget)) && !cpuHalted;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wrong resume mode");

    property p_standby_wake;
        (modeState == MODE_STANDBY && wakeIrq) |=> (modeState == MODE_ACTIVE);
    endproperty
    a_standby_wake: assert property (p_standby_wake)
        else $error("standby did not resume active");

    property p_sub_range;
        (subClkShift != 2'h0);
    endproperty
    a_sub_range: assert property (p_sub_range)
        else $error("sub clock shift out of range");

    property p_rsvd_store;
        (ctl.standbyReg[RSVD_BIT] == 1'b0);
    endproperty
    a_rsvd_store: assert property (p_rsvd_store)
        else $error("reserved standby bit stored");

    property p_sleep_entry;
        (sleepTaken && !ctl.modeClkReg[DIR_XFR_BIT] && !standbySelect
            && !ctl.modeClkReg[SLP_SEL_BIT]) |=> (modeState == MODE_SLEEP) && cpuHalted;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep not entered");

    property p_subsleep_entry;
        (sleepTaken && !ctl.modeClkReg[DIR_XFR_BIT] && !standbySelect
            && ctl.modeClkReg[SLP_SEL_BIT]) |=> (modeState == MODE_SUBSLEEP) && cpuHalted;
    endproperty
    a_subsleep_entry: assert property (p_subsleep_entry)
        else $error("subsleep not entered");

    property p_undef_ignored;
        (sleepExec && !cpuHalted && !ctl.modeClkReg[DIR_XFR_BIT] && !standbySelect
            && ctl.modeClkReg[SLP_SEL_BIT] && ctl.modeClkReg[LOW_SPD_BIT]) |=> $stable(modeState);
    endproperty
    a_undef_ignored: assert property (p_undef_ignored)
        else $error("undefined sleep combination changed mode");

    property p_halted_sleep;
        (sleepExec && cpuHalted && !wakeIrq) |=> $stable(modeState);
    endproperty
    a_halted_sleep: assert property (p_halted_sleep)
        else $error("sleep taken while halted");

    property p_wake_sub;
        (cpuHalted && wakeIrq && modeState != MODE_STANDBY && ctl.modeClkReg[LOW_SPD_BIT])
            |=> (modeState == MODE_SUBACTIVE);
    endproperty
    a_wake_sub: assert property (p_wake_sub)
        else $error("low-speed wake did not resume subactive");

    property p_wake_act;
        (cpuHalted && wakeIrq && !ctl.modeClkReg[LOW_SPD_BIT]) |=> (modeState == MODE_ACTIVE);
    endproperty
    a_wake_act: assert property (p_wake_act)
        else $error("wake did not resume active");

    property p_wake_ignored;
        (!cpuHalted && wakeIrq && !sleepExec) |=> $stable(modeState);
    endproperty
    a_wake_ignored: assert property (p_wake_ignored)
        else $error("wake moved a running mode");

    property p_sub_div2;
        (sleepTaken && ctl.modeClkReg[SA_MSB]) |=> (subClkShift == SHIFT_DIV2);
    endproperty
    a_sub_div2: assert property (p_sub_div2)
        else $error("sub clock code 1x not divide by two");

    property p_sub_div8;
        (sleepTaken && !ctl.modeClkReg[SA_MSB] && !ctl.modeClkReg[SA_LSB])
            |=> (subClkShift == SHIFT_DIV8);
    endproperty
    a_sub_div8: assert property (p_sub_div8)
        else $error("sub clock code 00 not divide by eight");

    property p_wdog_release;
        !ctl.standbyReg[WDOG_BIT] |=> !watchdogStandby;
    endproperty
    a_wdog_release: assert property (p_wdog_release)
        else $error("watchdog held in standby with bit clear");

    c_sleep:     cover property (sleepTaken && modeState == MODE_ACTIVE
                                 ##1 modeState == MODE_SLEEP ##[1:20] !cpuHalted);
    c_standby:   cover property (modeState == MODE_STANDBY ##1 modeState == MODE_ACTIVE);
    c_subactive: cover property (sleepTaken ##1 modeState == MODE_SUBACTIVE);
    c_wdog:      cover property (wrStandby && regWrData[WDOG_BIT] ##2 watchdogStandby);
endmodule

// file: pdmc_top_test.sv
module pdmc_top_test
    import pdmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sysClk;
    logic        arstN;
    logic [1:0]  regAddr;
    logic [7:0]  regWrData;
    logic        regWrEn;
    logic        regRdEn;
    logic [7:0]  regRdData;
    logic        standbySelect;
    logic        wdtClkIsOsc;
    logic        sleepExec;
    logic        wakeIrq;
    pdmc_mode_e  modeState;
    logic        cpuHalted;
    logic [2:0]  activeClkCode;
    logic [1:0]  subClkShift;
    logic [6:0]  stbyVec;
    int          failCount;
    int          checked;
    int          cycleCount;
    logic [2:0]  prevAct;
    logic [1:0]  prevShift;
    logic [2:0]  prevMode;

    // mode table, expectations worked out by hand from the transition rules
    logic [7:0]  cfgTab   [8] = '{8'h00, 8'h5d, 8'h8e, 8'h53, 8'h34, 8'h79, 8'hc0, 8'h20};
    logic        stbySelTab [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic [2:0]  modeTab  [8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h0, 3'h4, 3'h4, 3'h0};
    logic [2:0]  wakeTab  [8] = '{3'h0, 3'h4, 3'h0, 3'h0, 3'h0, 3'h4, 3'h4, 3'h0};
    logic [2:0]  actTab   [8] = '{3'h0, 3'h7, 3'h0, 3'h4, 3'h5, 3'h6, 3'h6, 3'h0};
    logic [1:0]  shiftTab [8] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2, 2'h3};

    pdmc_top uut
    (
        .sys_clk            (sysClk),
        .arst_n             (arstN),
        .regAddr            (regAddr),
        .regWrData          (regWrData),
        .regWrEn            (regWrEn),
        .regRdEn            (regRdEn),
        .regRdData          (regRdData),
        .standbySelect      (standbySelect),
        .wdtClkIsOsc        (wdtClkIsOsc),
        .sleepExec          (sleepExec),
        .wakeIrq            (wakeIrq),
        .modeState          (modeState),
        .cpuHalted          (cpuHalted),
        .activeClkCode      (activeClkCode),
        .subClkShift        (subClkShift),
        .twowireStandby     (stbyVec[6]),
        .serialStandby      (stbyVec[5]),
        .converterStandby   (stbyVec[4]),
        .watchdogStandby    (stbyVec[3]),
        .thirdTimerStandby  (stbyVec[2]),
        .secondTimerStandby (stbyVec[1]),
        .firstTimerStandby  (stbyVec[0])
    );

    always #2 sysClk = ~sysClk;

    // the whole run needs well under a thousand cycles
    always @(posedge sysClk)
    begin
        cycleCount = cycleCount + 1;
        if (cycleCount == 5000)
        begin
            failCount = failCount + 1;
            $display("unexpected at %0t: run did not finish in time", $time);
            complete_run();
        end
    end

    task automatic checkSig(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked = checked + 1;
        if (got !== exp)
        begin
            failCount = failCount + 1;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic regWrite(input logic [1:0] addr, input logic [7:0] data);
        @(posedge sysClk);
        regWrEn   <= 1'b1;
        regAddr   <= addr;
        regWrData <= data;
        @(posedge sysClk);
        regWrEn   <= 1'b0;
    endtask

    task automatic expectRead(input logic [1:0] addr, input logic [7:0] exp);
        @(posedge sysClk);
        regRdEn <= 1'b1;
        regAddr <= addr;
        @(posedge sysClk);
        regRdEn <= 1'b0;
        #1;
        checkSig(regRdData, exp, "read data");
    endtask

    // one-cycle pulse on sleep or wake, outputs settle one cycle later
    task automatic pulseEvent(input logic isWake);
        @(posedge sysClk);
        if (isWake)
            wakeIrq <= 1'b1;
        else
            sleepExec <= 1'b1;
        @(posedge sysClk);
        wakeIrq   <= 1'b0;
        sleepExec <= 1'b0;
        #1;
    endtask

    task automatic checkMode(input logic [2:0] expMode);
        checkSig({5'h0, modeState}, {5'h0, expMode}, "mode");
        checkSig({7'h0, cpuHalted}, {7'h0, expMode inside {3'h1, 3'h2, 3'h3}}, "halted");
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        sysClk = 1'b0;
        arstN = 1'b0;
        regAddr = 2'h0;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        standbySelect = 1'b0;
        wdtClkIsOsc = 1'b0;
        sleepExec = 1'b0;
        wakeIrq = 1'b0;
        failCount = 0;
        checked = 0;
        cycleCount = 0;
        repeat (2) @(posedge sysClk);
        arstN <= 1'b1;

        checkMode(3'h0);
        checkSig({1'b0, stbyVec}, 8'h00, "standby after reset");
        expectRead(2'h0, 8'h00);
        expectRead(2'h1, 8'h00);
        expectRead(2'h2, 8'hc0);
        $display("test reset values done");

        // walking one through every standby bit, watchdog on system clock
        for (int i = 0; i < 7; i++)
        begin
            regWrite(2'h1, 8'h01 << i);
            @(posedge sysClk);
            #1;
            checkSig({1'b0, stbyVec}, 8'h01 << i, "standby bit");
        end
        regWrite(2'h1, 8'hff);
        expectRead(2'h1, 8'h7f);
        checkSig({1'b0, stbyVec}, 8'h7f, "all standby");
        @(posedge sysClk);
        wdtClkIsOsc <= 1'b1;
        repeat (2) @(posedge sysClk);
        #1;
        checkSig({7'h0, stbyVec[3]}, 8'h00, "watchdog on oscillator");
        checkSig({2'h0, stbyVec[6:4], stbyVec[2:0]}, 8'h3f, "others kept");
        @(posedge sysClk);
        wdtClkIsOsc <= 1'b0;
        regWrite(2'h1, 8'h00);
        repeat (2) @(posedge sysClk);
        #1;
        checkSig({1'b0, stbyVec}, 8'h00, "standby released");
        $display("test module standby done");

        // unmapped and read-only places
        regWrite(2'h3, 8'hff);
        expectRead(2'h3, 8'h00);
        regWrite(2'h2, 8'h1f);
        expectRead(2'h2, 8'hc0);
        expectRead(2'h0, 8'h00);
        $display("test unmapped access done");

        // mode table; clock fields must hold until the sleep executes
        prevAct = 3'h0;
        prevShift = 2'h3;
        prevMode = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            regWrite(2'h0, cfgTab[i]);
            @(posedge sysClk);
            standbySelect <= stbySelTab[i];
            expectRead(2'h0, cfgTab[i]);
            checkMode(prevMode);
            checkSig({5'h0, activeClkCode}, {5'h0, prevAct}, "active code early");
            checkSig({6'h0, subClkShift}, {6'h0, prevShift}, "sub shift early");
            pulseEvent(1'b0);
            checkMode(modeTab[i]);
            checkSig({5'h0, activeClkCode}, {5'h0, actTab[i]}, "active code");
            checkSig({6'h0, subClkShift}, {6'h0, shiftTab[i]}, "sub shift");
            expectRead(2'h2, {shiftTab[i], actTab[i], modeTab[i]});
            pulseEvent(1'b1);
            checkMode(wakeTab[i]);
            prevAct = actTab[i];
            prevShift = shiftTab[i];
            prevMode = wakeTab[i];
            @(posedge sysClk);
            standbySelect <= 1'b0;
        end
        $display("test mode transitions done");

        // a second sleep while halted must not move the mode
        regWrite(2'h0, 8'h00);
        pulseEvent(1'b0);
        checkMode(3'h1);
        regWrite(2'h0, 8'h34);
        pulseEvent(1'b0);
        checkMode(3'h1);
        checkSig({5'h0, activeClkCode}, 8'h00, "clock held while halted");
        pulseEvent(1'b1);
        checkMode(3'h0);
        $display("test halted sleep done");

        // mid-run reset must clear both registers and the applied state
        regWrite(2'h1, 8'h55);
        regWrite(2'h0, 8'h5d);
        pulseEvent(1'b0);
        checkMode(3'h1);
        checkSig({1'b0, stbyVec}, 8'h55, "standby before reset");
        @(posedge sysClk);
        arstN <= 1'b0;
        @(posedge sysClk);
        #1;
        checkMode(3'h0);
        checkSig({1'b0, stbyVec}, 8'h00, "standby in reset");
        @(posedge sysClk);
        arstN <= 1'b1;
        expectRead(2'h0, 8'h00);
        expectRead(2'h1, 8'h00);
        expectRead(2'h2, 8'hc0);
        $display("test mid-run reset done");

        complete_run();
    end
endmodule
